// ==== sac_pkg.sv ====
// How it works
// - device is clock slave; source drives clocks
// - bit clock 32/48/64 fs, checked
// - frame clock exactly one cycle per sample
// - proc clock from master clock, else oscillator
// - rates detected and applied without software
// - clock fault: hard mute, then oscillator limp mode
// - stable clocks: resume, hard or soft unmute
// - 16/20/24-bit words, three framings accepted
// - standard framing: frame low left, high right
// - standard framing: first bit one period late
// - msb first, sampled on bit clock rise
// - trailing slot bits ignored in standard/left-aligned
// - aligned framings: frame high left, low right
// - left-aligned: msb in the toggle period
// - right-aligned: lsb in last period before toggle
// - right-aligned: leading slot bits ignored
// - samples are two's complement, msb first
package sac_pkg;
    typedef enum logic [1:0] {
        SAC_STD            = 2'h0,
        SAC_LEFT_ALIGNED   = 2'h1,
        SAC_RIGHT_ALIGNED  = 2'h2
    } sac_fmt_t;

    // rx state, gray along limp -> ramp -> run
    typedef enum logic [1:0] {
        SAC_LIMP = 2'h0,
        SAC_RAMP = 2'h1,
        SAC_RUN  = 2'h3
    } sac_state_t;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned PROC_CLK_MULT = 512;
    localparam int unsigned FRAME_TMO_US  = 200;
    localparam int unsigned FRAME_TMO_CYC = FRAME_TMO_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned MCLK_TMO_NS   = 1000;
    localparam int unsigned MCLK_TMO_CYC  = MCLK_TMO_NS / CLK_PERIOD_NS;
    localparam int unsigned STABLE_FRAMES = 4;
    localparam int unsigned BCLK_HALF     = 4;
    localparam int unsigned MCLK_HALF     = 2;

    // register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_IRQ    = 8'h02;
    localparam logic [7:0] REG_MASK   = 8'h03;
    localparam logic [7:0] REG_PER_LO = 8'h04;
    localparam logic [7:0] REG_PER_HI = 8'h05;
    localparam logic [7:0] REG_VOLUME = 8'h0e;

    // field positions and resets
    localparam int unsigned CTRL_FMT_LSB = 0;
    localparam int unsigned CTRL_WL_LSB  = 2;
    localparam int unsigned VOL_SOFT_BIT = 7;
    localparam int unsigned IRQ_ERR_BIT  = 0;
    localparam int unsigned IRQ_LOCK_BIT = 1;
    localparam int unsigned IRQ_PAIR_BIT = 2;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] VOLUME_RESET = 8'h7f;
    localparam logic [7:0] MASK_RESET   = 8'h00;
endpackage

// ==== sac_link_if.sv ====
`timescale 1ns/1ps
interface sac_link_if;
    logic mclk;
    logic bclk;
    logic fclk;
    logic sdata;

    modport dev (input mclk, input bclk, input fclk, input sdata);
    modport src (output mclk, output bclk, output fclk, output sdata);
endinterface

// ==== sac_rx.sv ====
`timescale 1ns/1ps
module sac_rx #(
    parameter int unsigned FRAME_TMO = sac_pkg::FRAME_TMO_CYC,
    parameter int unsigned MCLK_TMO  = sac_pkg::MCLK_TMO_CYC,
    parameter int unsigned STABLE_N  = sac_pkg::STABLE_FRAMES
) (
    // system
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // link
    sac_link_if.dev          link,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // processing path
    output logic      [23:0] left_word,
    output logic      [23:0] right_word,
    output logic             pair_valid,
    output logic             muted,
    output logic             osc_ref,
    output logic      [6:0]  gain,
    output logic             irq
);
    if (FRAME_TMO < 1024 || FRAME_TMO > 65535 || MCLK_TMO < 8 || MCLK_TMO > 255
        || STABLE_N < 1 || STABLE_N > 15)
        $error("sac_rx: parameter out of range");

    localparam logic [15:0] FTMO = 16'(FRAME_TMO - 1);
    localparam logic [7:0]  MTMO = 8'(MCLK_TMO - 1);
    localparam logic [3:0]  SLAST = 4'(STABLE_N - 1);

    // three-stage sync; level moves once stages 2 and 3 agree
    logic [3:0] s1, s2, s3, f, fq;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1 <= 4'h0;
            s2 <= 4'h0;
            s3 <= 4'h0;
            f  <= 4'h0;
            fq <= 4'h0;
        end
        else if (ce)
        begin
            s1 <= {link.mclk, link.bclk, link.fclk, link.sdata};
            s2 <= s1;
            s3 <= s2;
            f  <= (s2 & s3) | (f & (s2 | s3));
            fq <= f;
        end
    end

    wire mclk_e = f[3] ^ fq[3];
    wire bclk_r = f[2] & ~fq[2];
    wire fclk_e = f[1] ^ fq[1];
    wire fclk_r = f[1] & ~fq[1];

    // registers
    logic [7:0] ctrl, vol_cfg, mask, irq_st, status;
    logic [15:0] per;
    sac_pkg::sac_state_t state;
    logic ev_err, ev_lock;
    sac_pkg::sac_fmt_t fmt;
    logic [4:0] wl;

    always_comb
    begin
        fmt = sac_pkg::sac_fmt_t'(ctrl[sac_pkg::CTRL_FMT_LSB +: 2]);
        case (ctrl[sac_pkg::CTRL_WL_LSB +: 2])
            2'h0:    wl = 5'h10;
            2'h1:    wl = 5'h14;
            default: wl = 5'h18;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl    <= sac_pkg::CTRL_RESET;
            vol_cfg <= sac_pkg::VOLUME_RESET;
            mask    <= sac_pkg::MASK_RESET;
        end
        else if (ce && reg_wr)
        begin
            if (reg_addr == sac_pkg::REG_CTRL)
                ctrl <= reg_wdata;
            else if (reg_addr == sac_pkg::REG_MASK)
                mask <= reg_wdata;
            else if (reg_addr == sac_pkg::REG_VOLUME)
                vol_cfg <= reg_wdata;
        end
    end

    // read clears; a new event in the same cycle survives
    wire irq_rd = reg_rd && reg_addr == sac_pkg::REG_IRQ;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_st <= 8'h00;
        else if (ce)
            irq_st <= (irq_rd ? 8'h00 : irq_st)
                    | (8'(ev_err) << sac_pkg::IRQ_ERR_BIT)
                    | (8'(ev_lock) << sac_pkg::IRQ_LOCK_BIT)
                    | (8'(pair_valid) << sac_pkg::IRQ_PAIR_BIT);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else if (ce)
            irq <= |(irq_st & mask);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (ce)
        begin
            if (!reg_rd)
                reg_rdata <= 8'h00;
            else if (reg_addr == sac_pkg::REG_CTRL)
                reg_rdata <= ctrl;
            else if (reg_addr == sac_pkg::REG_STATUS)
                reg_rdata <= status;
            else if (reg_addr == sac_pkg::REG_IRQ)
                reg_rdata <= irq_st;
            else if (reg_addr == sac_pkg::REG_MASK)
                reg_rdata <= mask;
            else if (reg_addr == sac_pkg::REG_PER_LO)
                reg_rdata <= per[7:0];
            else if (reg_addr == sac_pkg::REG_PER_HI)
                reg_rdata <= per[15:8];
            else if (reg_addr == sac_pkg::REG_VOLUME)
                reg_rdata <= vol_cfg;
            else
                reg_rdata <= 8'h00;
        end
    end

    // deserialiser
    logic [31:0] sh;
    logic [5:0]  bcnt, slot;
    logic [4:0]  got;
    logic        armed, skip, wch;
    // std framing with slot == wl: the lsb lands in the delay bit of the next slot
    logic        tail, tch;
    logic [1:0]  ratio;
    wire right_now = f[1] ^ (fmt != sac_pkg::SAC_STD);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sh    <= 32'h0;
            bcnt  <= 6'h0;
            got   <= 5'h0;
            armed <= 1'b0;
            skip  <= 1'b0;
            wch   <= 1'b0;
            tail  <= 1'b0;
            tch   <= 1'b0;
        end
        else if (ce)
        begin
            if (fclk_e)
            begin
                bcnt  <= 6'h0;
                armed <= fmt != sac_pkg::SAC_RIGHT_ALIGNED;
                skip  <= fmt == sac_pkg::SAC_STD;
                got   <= 5'h0;
                wch   <= right_now;
                tail  <= fmt == sac_pkg::SAC_STD && armed && got + 5'h1 == wl;
                tch   <= wch;
            end
            else if (bclk_r)
            begin
                sh <= {sh[30:0], f[0]};
                if (bcnt != 6'h3f)
                    bcnt <= bcnt + 6'h1;
                if (skip)
                begin
                    skip <= 1'b0;
                    tail <= 1'b0;
                end
                else if (armed)
                begin
                    got <= got + 5'h1;
                    if (got + 5'h1 == wl)
                        armed <= 1'b0;
                end
            end
        end
    end

    // keep the last wl bits, msb-aligned in 24
    function automatic logic [23:0] align(input logic [31:0] v, input logic [4:0] n);
        case (n)
            5'h10:   align = {v[15:0], 8'h00};
            5'h14:   align = {v[19:0], 4'h0};
            default: align = v[23:0];
        endcase
    endfunction

    logic emit, emit_r;
    logic [23:0] word;
    always_comb
    begin
        emit   = 1'b0;
        emit_r = wch;
        word   = align({sh[30:0], f[0]}, wl);
        if (fclk_e && fmt == sac_pkg::SAC_RIGHT_ALIGNED)
        begin
            emit   = 1'b1;
            emit_r = ~right_now;
            word   = align(sh, wl);
        end
        else if (!fclk_e && bclk_r && armed && !skip && got + 5'h1 == wl)
            emit = 1'b1;
        else if (!fclk_e && bclk_r && skip && tail)
        begin
            emit   = 1'b1;
            emit_r = tch;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            left_word  <= 24'h0;
            right_word <= 24'h0;
            pair_valid <= 1'b0;
        end
        else if (ce)
        begin
            pair_valid <= emit && emit_r;
            // a held word would keep playing, so mute clears both at once
            if (muted)
            begin
                left_word  <= 24'h0;
                right_word <= 24'h0;
            end
            else if (emit && emit_r)
                right_word <= word;
            else if (emit)
                left_word <= word;
        end
    end

    // clock checking and rate detection
    logic [15:0] ftmo, fcnt;
    logic [7:0]  mtmo;
    logic [3:0]  gcnt;
    wire mclk_ok = mtmo != MTMO;
    wire slot_ok = (bcnt == 6'h10 || bcnt == 6'h18 || bcnt == 6'h20)
                   && bcnt == slot;
    wire err = (fclk_e && !slot_ok) || ftmo == FTMO || !mclk_ok;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ftmo  <= 16'h0;
            fcnt  <= 16'h0;
            per   <= 16'h0;
            mtmo  <= 8'h0;
            slot  <= 6'h0;
            ratio <= 2'h0;
        end
        else if (ce)
        begin
            ftmo <= (fclk_e || ftmo == FTMO) ? 16'h0 : ftmo + 16'h1;
            mtmo <= mclk_e ? 8'h0 : (mclk_ok ? mtmo + 8'h1 : mtmo);
            fcnt <= fclk_r ? 16'h1 : (fcnt == 16'hffff ? fcnt : fcnt + 16'h1);
            if (fclk_r)
                per <= fcnt;
            if (fclk_e)
            begin
                slot <= bcnt;
                if (slot_ok)
                    ratio <= bcnt == 6'h10 ? 2'h0 : (bcnt == 6'h18 ? 2'h1 : 2'h2);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state   <= sac_pkg::SAC_LIMP;
            gcnt    <= 4'h0;
            gain    <= 7'h0;
            ev_err  <= 1'b0;
            ev_lock <= 1'b0;
        end
        else if (ce)
        begin
            ev_err  <= 1'b0;
            ev_lock <= 1'b0;
            case (state)
                sac_pkg::SAC_LIMP:
                begin
                    gain <= 7'h0;
                    if (err)
                        gcnt <= 4'h0;
                    else if (fclk_e && gcnt != SLAST)
                        gcnt <= gcnt + 4'h1;
                    else if (fclk_e)
                    begin
                        gcnt    <= 4'h0;
                        ev_lock <= 1'b1;
                        if (vol_cfg[sac_pkg::VOL_SOFT_BIT])
                            state <= sac_pkg::SAC_RAMP;
                        else
                        begin
                            state <= sac_pkg::SAC_RUN;
                            gain  <= vol_cfg[6:0];
                        end
                    end
                end
                sac_pkg::SAC_RAMP:
                begin
                    if (err)
                    begin
                        state  <= sac_pkg::SAC_LIMP;
                        gain   <= 7'h0;
                        ev_err <= 1'b1;
                    end
                    else if (gain >= vol_cfg[6:0])
                        state <= sac_pkg::SAC_RUN;
                    else if (fclk_r)
                        gain <= gain + 7'h1;
                end
                default:
                begin
                    if (err)
                    begin
                        state  <= sac_pkg::SAC_LIMP;
                        gain   <= 7'h0;
                        ev_err <= 1'b1;
                    end
                    else
                        gain <= vol_cfg[6:0];
                end
            endcase
        end
    end

    assign muted   = state == sac_pkg::SAC_LIMP;
    assign osc_ref = muted;
    assign status  = {3'h0, ratio, mclk_ok, osc_ref, ~muted};
endmodule

// ==== sac_tx.sv ====
`timescale 1ns/1ps
module sac_tx #(
    parameter int unsigned BCLK_HALF_CYC = sac_pkg::BCLK_HALF,
    parameter int unsigned MCLK_HALF_CYC = sac_pkg::MCLK_HALF
) (
    // system
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // link
    sac_link_if.src          link,
    // user side
    input  wire logic        run,
    input  wire logic [1:0]  fmt,
    input  wire logic [1:0]  wl_code,
    input  wire logic [1:0]  ratio,
    input  wire logic [23:0] left_in,
    input  wire logic [23:0] right_in,
    output logic             take
);
    if (BCLK_HALF_CYC < 4 || BCLK_HALF_CYC > 15 || MCLK_HALF_CYC < 2 || MCLK_HALF_CYC > 15)
        $error("sac_tx: divider out of range");

    localparam logic [4:0] BH = 5'(BCLK_HALF_CYC);
    localparam logic [3:0] MH = 4'(MCLK_HALF_CYC - 1);

    logic [4:0]  div;
    logic [3:0]  mdiv;
    logic [5:0]  pos;
    logic [31:0] sh;
    logic [23:0] lbuf, rbuf;
    logic        bclk, fclk, mclk;

    wire [5:0] slot = ratio == 2'h0 ? 6'h10 : (ratio == 2'h1 ? 6'h18 : 6'h20);
    wire [5:0] wl   = wl_code == 2'h0 ? 6'h10 : (wl_code == 2'h1 ? 6'h14 : 6'h18);
    wire [23:0] wmask = wl_code == 2'h0 ? 24'hffff00 : (wl_code == 2'h1 ? 24'hfffff0 : 24'hffffff);
    wire fall  = run && div == 5'((BCLK_HALF_CYC * 2) - 1);
    wire wrap  = pos == slot - 6'h1;
    wire [5:0] np = wrap ? 6'h0 : pos + 6'h1;
    wire nf    = wrap ? ~fclk : fclk;
    wire nright = nf ^ (fmt != 2'(sac_pkg::SAC_STD));
    wire [5:0] ld = fmt == 2'(sac_pkg::SAC_STD) ? 6'h1
                  : (fmt == 2'(sac_pkg::SAC_LEFT_ALIGNED) ? 6'h0 : slot - wl);
    wire new_pair = fall && wrap && !nright;

    // bit and master clocks from dividers; the source is the clock master
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div  <= 5'h0;
            mdiv <= 4'h0;
            bclk <= 1'b0;
            mclk <= 1'b0;
        end
        else if (ce)
        begin
            if (!run)
            begin
                div  <= 5'h0;
                mdiv <= 4'h0;
                bclk <= 1'b0;
                mclk <= 1'b0;
            end
            else
            begin
                div  <= fall ? 5'h0 : div + 5'h1;
                mdiv <= mdiv == MH ? 4'h0 : mdiv + 4'h1;
                if (mdiv == MH)
                    mclk <= ~mclk;
                if (div == BH - 5'h1)
                    bclk <= 1'b1;
                else if (fall)
                    bclk <= 1'b0;
            end
        end
    end

    // data and frame move on the bit clock fall
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pos  <= 6'h0;
            fclk <= 1'b0;
            sh   <= 32'h0;
            lbuf <= 24'h0;
            rbuf <= 24'h0;
            take <= 1'b0;
        end
        else if (ce)
        begin
            take <= new_pair;
            if (new_pair)
            begin
                lbuf <= left_in;
                rbuf <= right_in;
            end
            if (fall)
            begin
                pos  <= np;
                fclk <= nf;
                if (np == ld)
                    sh <= {(nright ? rbuf : (new_pair ? left_in : lbuf)) & wmask, 8'h00};
                else
                    sh <= {sh[30:0], 1'b0};
            end
        end
    end

    assign link.mclk  = mclk;
    assign link.bclk  = bclk;
    assign link.fclk  = fclk;
    assign link.sdata = sh[31];
endmodule

// ==== sac_assertions.sv ====
`timescale 1ns/1ps
module sac_assertions (
    // system
    input logic clk,
    input logic rst_n,
    // link
    input logic mclk,
    input logic bclk,
    input logic fclk,
    input logic sdata
);
    logic       pb;
    logic       pf;
    logic       pm;
    logic       seen;
    logic       edge_f;
    logic [2:0] idl;
    logic [5:0] cnt;

    assign edge_f = fclk != pf;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pb <= 1'b0;
            pf <= 1'b0;
            pm <= 1'b0;
        end
        else
        begin
            pb <= bclk;
            pf <= fclk;
            pm <= mclk;
        end
    end

    // a stopped master clock means the source halted; first slot after it is partial
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            idl  <= 3'h0;
            cnt  <= 6'h00;
            seen <= 1'b0;
        end
        else
        begin
            if (mclk != pm)
                idl <= 3'h0;
            else if (idl != 3'h7)
                idl <= idl + 3'h1;
            if (idl >= 3'h4 || edge_f)
                cnt <= 6'h00;
            else if (bclk && !pb)
                cnt <= cnt + 6'h01;
            if (idl >= 3'h4)
                seen <= 1'b0;
            else if (edge_f)
                seen <= 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_fclk_at_fall;
        $changed(fclk) |-> $fell(bclk);
    endproperty
    property p_data_hold;
        $rose(bclk) |-> $stable(sdata)[*4];
    endproperty
    property p_high_len;
        $rose(bclk) |-> bclk[*4] ##1 !bclk;
    endproperty
    property p_low_len;
        $fell(bclk) |-> !bclk[*4];
    endproperty
    property p_period;
        $rose(bclk) |=> !$rose(bclk)[*7];
    endproperty
    property p_slot_len;
        seen && edge_f |-> cnt inside {6'h10, 6'h18, 6'h20};
    endproperty
    property p_slot_max;
        seen |-> cnt <= 6'h20;
    endproperty
    property p_mclk_live;
        $rose(bclk) |-> ##[1:3] $changed(mclk);
    endproperty

    a_fclk_at_fall: assert property (p_fclk_at_fall)
        else $error("frame clock moved off a bit clock fall");
    a_data_hold: assert property (p_data_hold)
        else $error("data moved while bit clock high");
    a_high_len: assert property (p_high_len)
        else $error("bit clock high phase wrong");
    a_low_len: assert property (p_low_len)
        else $error("bit clock low phase short");
    a_period: assert property (p_period)
        else $error("bit clock period short");
    a_slot_len: assert property (p_slot_len)
        else $error("slot length not 16, 24 or 32");
    a_slot_max: assert property (p_slot_max)
        else $error("slot longer than 32 bits");
    a_mclk_live: assert property (p_mclk_live)
        else $error("master clock absent while bit clock runs");

    c_slot16: cover property (seen && edge_f && cnt == 6'h10);
    c_slot24: cover property (seen && edge_f && cnt == 6'h18);
    c_slot32: cover property (seen && edge_f && cnt == 6'h20);
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    localparam logic [23:0] LW = 24'h9a5c3e;
    localparam logic [23:0] RW = 24'h4b1d72;

    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [23:0] left_word;
    logic [23:0] right_word;
    logic        pair_valid;
    logic        muted;
    logic        osc_ref;
    logic [6:0]  gain;
    logic        irq;
    logic        run;
    logic [1:0]  fmt;
    logic [1:0]  wl_code;
    logic [1:0]  ratio;
    logic [23:0] left_in;
    logic [23:0] right_in;
    int          failures;
    int          comparisons;

    sac_link_if sac_link_if_i ();

    sac_rx #(.FRAME_TMO(1024)) sac_rx_i (
        .clk(clk), .rst_n(rst_n), .ce(ce), .link(sac_link_if_i),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .left_word(left_word), .right_word(right_word),
        .pair_valid(pair_valid), .muted(muted), .osc_ref(osc_ref), .gain(gain), .irq(irq)
    );

    sac_tx sac_tx_i (
        .clk(clk), .rst_n(rst_n), .ce(ce), .link(sac_link_if_i), .run(run), .fmt(fmt),
        .wl_code(wl_code), .ratio(ratio), .left_in(left_in), .right_in(right_in), .take()
    );

    sac_assertions sac_assertions_i (
        .clk(clk), .rst_n(rst_n), .mclk(sac_link_if_i.mclk), .bclk(sac_link_if_i.bclk),
        .fclk(sac_link_if_i.fclk), .sdata(sac_link_if_i.sdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report;
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // k: 0 muted, 1 unmuted, 2 pair pulse
    task automatic wt(input int k, input int lim);
        int n;
        n = 0;
        while (n < lim && !(k == 0 ? muted === 1'b1 : k == 1 ? muted === 1'b0
                                   : pair_valid === 1'b1))
        begin
            @(posedge clk);
            n++;
        end
        chk("wait", n < lim, 24'h1);
    endtask

    // halt only in the low phase so no bit clock high phase is cut short
    task automatic stop_link;
        if (run)
        begin
            @(negedge sac_link_if_i.bclk);
            @(posedge clk);
            run <= 1'b0;
        end
        wt(0, 500);
    endtask

    task automatic cap(input logic lvl, input int skip, input int n, output logic [23:0] w);
        int   i;
        logic pb;
        w  = 24'h0;
        pb = 1'b1;
        i  = 0;
        while (sac_link_if_i.fclk === lvl)
            @(posedge clk);
        while (sac_link_if_i.fclk !== lvl)
            @(posedge clk);
        while (i < skip + n)
        begin
            @(posedge clk);
            if (sac_link_if_i.bclk && !pb)
            begin
                if (i >= skip)
                    w = {w[22:0], sac_link_if_i.sdata};
                i++;
            end
            pb = sac_link_if_i.bclk;
        end
    endtask

    task automatic t_reset;
        logic [7:0] d;
        logic [7:0] ad [4] = '{8'h00, 8'h0e, 8'h03, 8'h20};
        logic [7:0] ex [4] = '{8'h00, 8'h7f, 8'h00, 8'h00};
        chk("muted", muted, 24'h1);
        chk("irq", irq, 24'h0);
        foreach (ad[i])
        begin
            rd(ad[i], d);
            chk("reg", d, ex[i]);
        end
        wr(sac_pkg::REG_STATUS, 8'hff);
        rd(sac_pkg::REG_STATUS, d);
        chk("status", d[1:0], 24'h2);
    endtask

    task automatic t_combo(input logic [1:0] f, input logic [1:0] w, input logic [1:0] r);
        logic [7:0]  d;
        logic [7:0]  lo;
        logic [23:0] m;
        logic [23:0] bits;
        int          n;
        n = 16 + 4 * w;
        m = 24'hffffff << (24 - n);
        stop_link;
        wr(sac_pkg::REG_CTRL, {4'h0, w, f});
        @(posedge clk);
        fmt     <= f;
        wl_code <= w;
        ratio   <= r;
        run     <= 1'b1;
        wt(1, 8000);
        chk("gain", gain, 24'h7f);
        chk("osc_ref", osc_ref, 24'h0);
        wt(2, 3000);
        @(posedge clk);
        wt(2, 3000);
        chk("left", left_word, LW & m);
        chk("right", right_word, RW & m);
        rd(sac_pkg::REG_STATUS, d);
        chk("status", d, {3'h0, r, 3'h5});
        rd(sac_pkg::REG_PER_LO, lo);
        rd(sac_pkg::REG_PER_HI, d);
        chk("period", {d, lo}, 24'((r + 2) * 128));
        cap(f != 2'h0, f == 2'h0 ? 1 : f == 2'h1 ? 0 : 16 + 8 * r - n, n, bits);
        chk("wire", bits, LW >> (24 - n));
    endtask

    task automatic t_irq;
        logic [7:0] d;
        rd(sac_pkg::REG_IRQ, d);
        wr(sac_pkg::REG_MASK, 8'h03);
        stop_link;
        repeat (2) @(posedge clk);
        chk("irq", irq, 24'h1);
        chk("left", left_word, 24'h0);
        chk("gain", gain, 24'h0);
        chk("osc_ref", osc_ref, 24'h1);
        rd(sac_pkg::REG_IRQ, d);
        chk("irq_st", d & 8'h03, 24'h1);
        repeat (2) @(posedge clk);
        chk("irq", irq, 24'h0);
        @(posedge clk);
        run <= 1'b1;
        wt(1, 8000);
        repeat (2) @(posedge clk);
        chk("irq", irq, 24'h1);
        rd(sac_pkg::REG_IRQ, d);
        chk("irq_st", d & 8'h03, 24'h2);
        wr(sac_pkg::REG_MASK, 8'h00);
    endtask

    task automatic t_soft;
        wr(sac_pkg::REG_VOLUME, 8'h85);
        stop_link;
        @(posedge clk);
        run <= 1'b1;
        wt(1, 8000);
        chk("ramp", gain, 24'h0);
        repeat (4000) @(posedge clk);
        chk("gain", gain, 24'h05);
        chk("muted", muted, 24'h0);
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        failures++;
        final_report;
    end

    initial
    begin
        int r;
        rst_n       = 1'b0;
        ce          = 1'b1;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        run         = 1'b0;
        fmt         = 2'h0;
        wl_code     = 2'h0;
        ratio       = 2'h0;
        left_in     = LW;
        right_in    = RW;
        failures    = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        for (int f = 0; f < 3; f++)
        begin
            for (int w = 0; w < 3; w++)
            begin
                r = (f + w) % 3;
                if (w != 0 && r == 0)
                    r = 2;
                t_combo(2'(f), 2'(w), 2'(r));
            end
        end
        t_irq;
        t_soft;
        final_report;
    end
endmodule
